// [design/rbs_crc16.sv]
// serial CRC-16 signature register
`timescale 1ns/1ps
module rbs_crc16 (
   // clock and control
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        ce_i,
   // step control
   input  wire logic        clear_i,
   input  wire logic        step_i,
   input  wire logic        bit_i,
   // signature
   output logic [15:0]      crc_o
);
   logic fb;

   assign fb = bit_i ^ crc_o[15];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         crc_o <= rbs_pkg::CRC_RESET;
      end else if (ce_i) begin
         if (clear_i) begin
            crc_o <= rbs_pkg::CRC_RESET;
         end else if (step_i) begin
            crc_o <= {crc_o[14:0], 1'b0} ^ (fb ? rbs_pkg::CRC_POLY : 16'h0000);
         end
      end
   end
endmodule // rbs_crc16

// [design/rbs_pkg.sv]
// constants and types for the configuration readback shifter
// What this block does
// - rising trigger, sampled on readback clock, starts readback
// - accepted trigger snapshots nodes into holding register
// - abort option: trigger fall aborts running readback
// - in-progress high exactly while readback runs
// - in-progress rises one clock after trigger
// - in-progress falls with last bit out
// - after abort, in-progress holds until termination
// - one bit shifted out per readback clock rise
// - capture disabled: user bit positions read ones
// - no user clock: configuration clock drives readback
// - stream opens with five dummy bits
// - frame: start zero, data, four one stops
// - eleven-bit CRC-16 signature after last frame
// - configuration bits true, user bits inverted
// - first two bits show speed, check mode
// - last seven bits of last frame ones
// - RAM contents travel in configuration data
// - no capture, no RAM: signature stays constant
// - abort termination: frames plus three clocks, data high
// - signature is top eleven CRC bits
package rbs_pkg;
   // -------------------------------------------------------------
   // stream geometry
   // -------------------------------------------------------------
   localparam int NUM_FRAMES      = 4;
   localparam int FRAME_DATA_BITS = 16;
   localparam int HOLD_BITS       = NUM_FRAMES * FRAME_DATA_BITS;
   localparam int DUMMY_BITS      = 5;
   localparam int STOP_BITS       = 4;
   localparam int FRAME_LAST_OFF  = FRAME_DATA_BITS + STOP_BITS;
   localparam int STATUS_BITS     = 2;
   localparam int LAST_ONES       = 7;
   localparam int CRC_WIDTH       = 16;
   localparam int CRC_OUT_BITS    = 11;
   localparam logic [15:0] CRC_POLY    = 16'h8005;
   localparam logic [15:0] CRC_RESET   = 16'h0000;
   localparam int TERM_EXTRA      = 3;
   localparam int TERM_CLKS       = NUM_FRAMES + TERM_EXTRA;
   localparam logic [1:0] USER_BIT_SEL = 2'h3;
   // -------------------------------------------------------------
   // sequencer states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DUMMY = 3'b001,
      ST_FRAME = 3'b010,
      ST_CRC   = 3'b011,
      ST_DONE  = 3'b100,
      ST_TERM  = 3'b101
   } rbs_state_t;
endpackage

// [design/rbs_readback_shifter.sv]
// readback sequencer, holding register and serial output
`timescale 1ns/1ps
module rbs_readback_shifter (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        ce_i,
   // readback pins (asynchronous)
   input  wire logic        readback_clk_pin_i,
   input  wire logic        config_clk_pin_i,
   input  wire logic        readback_trigger_pin_i,
   output logic             readback_data_pin_o,
   output logic             readback_in_progress_pin_o,
   // options and device status
   input  wire logic        user_clk_connected_i,
   input  wire logic        abort_on_trigger_fall_option_i,
   input  wire logic        user_state_capture_option_i,
   input  wire logic        cfg_speed_i,
   input  wire logic        cfg_check_mode_i,
   // configuration / RAM write port
   input  wire logic        cfg_wr_i,
   input  wire logic [1:0]  cfg_addr_i,
   input  wire logic [15:0] cfg_data_i,
   // live user nodes
   input  wire logic [63:0] user_nodes_i
);
   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic [15:0]          cfg_mem_r [rbs_pkg::NUM_FRAMES];
   logic [63:0]          hold_r;
   logic [2:0]           pins_s;
   logic                 rb_clk_s;
   logic                 readback_trigger_s;
   logic                 rb_prev_r;
   logic                 rb_edge;
   logic                 readback_trigger_smp_r;
   logic                 readback_trigger_rise;
   logic                 readback_trigger_fall;
   rbs_pkg::rbs_state_t  state_r;
   logic [4:0]           cnt_r;
   logic [1:0]           frame_r;
   logic [15:0]          crc;
   logic                 frame_bit;
   logic                 crc_step;
   logic                 active;
   logic                 abort_req;
   logic [5:0]           hold_idx;

   // -------------------------------------------------------------
   // helper functions
   // -------------------------------------------------------------
   function automatic logic is_user_bit(input int idx);
      logic [5:0] i6;
      i6 = 6'(idx);
      return (i6[1:0] == rbs_pkg::USER_BIT_SEL);
   endfunction

   function automatic logic [63:0] snapshot(input logic [63:0] cfg_flat, input logic [63:0] nodes,
                                            input logic capture, input logic spd, input logic chk);
      logic [63:0] v;
      v = '0;
      for (int i = 0; i < rbs_pkg::HOLD_BITS; i++) begin
         if (i >= rbs_pkg::HOLD_BITS - rbs_pkg::LAST_ONES) begin
            v[i] = 1'b1;
         end else if (i < rbs_pkg::STATUS_BITS) begin
            v[i] = (i == 0) ? spd : chk;
         end else if (is_user_bit(i)) begin
            v[i] = capture ? ~nodes[i] : 1'b1;
         end else begin
            v[i] = cfg_flat[i];
         end
      end
      return v;
   endfunction

   // -------------------------------------------------------------
   // pin synchronisers and clock selection
   // -------------------------------------------------------------
   rbs_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .async_i ({readback_trigger_pin_i, config_clk_pin_i, readback_clk_pin_i}),
      .sync_o  (pins_s)
   );

   // unconnected user clock falls back to configuration clock
   assign rb_clk_s = user_clk_connected_i ? pins_s[0] : pins_s[1];
   assign readback_trigger_s   = pins_s[2];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rb_prev_r <= 1'b0;
      end else if (ce_i) begin
         rb_prev_r <= rb_clk_s;
      end
   end

   assign rb_edge = ce_i & rb_clk_s & ~rb_prev_r;

   // -------------------------------------------------------------
   // trigger sampling on readback clock
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         readback_trigger_smp_r <= 1'b0;
      end else if (rb_edge) begin
         readback_trigger_smp_r <= readback_trigger_s;
      end
   end

   assign readback_trigger_rise = rb_edge & readback_trigger_s & ~readback_trigger_smp_r;
   assign readback_trigger_fall = rb_edge & ~readback_trigger_s & readback_trigger_smp_r;
   assign active    = (state_r != rbs_pkg::ST_IDLE) && (state_r != rbs_pkg::ST_TERM);
   assign abort_req = readback_trigger_fall & abort_on_trigger_fall_option_i & active;

   // -------------------------------------------------------------
   // configuration memory, also written by RAM use
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (ce_i && cfg_wr_i) begin
         cfg_mem_r[cfg_addr_i] <= cfg_data_i;
      end
   end

   // -------------------------------------------------------------
   // holding register capture
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hold_r <= '1;
      end else if (readback_trigger_rise && state_r == rbs_pkg::ST_IDLE) begin
         hold_r <= snapshot({cfg_mem_r[3], cfg_mem_r[2], cfg_mem_r[1], cfg_mem_r[0]}, user_nodes_i,
                            user_state_capture_option_i, cfg_speed_i, cfg_check_mode_i);
      end
   end

   // -------------------------------------------------------------
   // bit selection for the position the counters point at
   // -------------------------------------------------------------
   assign hold_idx = {frame_r, 4'(cnt_r - 5'h01)};

   always_comb begin
      if (cnt_r == 5'h00) begin
         frame_bit = 1'b0;
      end else if (cnt_r > 5'(rbs_pkg::FRAME_DATA_BITS)) begin
         frame_bit = 1'b1;
      end else begin
         frame_bit = hold_r[hold_idx];
      end
   end

   assign crc_step = rb_edge & (state_r == rbs_pkg::ST_FRAME) & ~abort_req;

   // constant inputs give a constant signature, nothing else feeds it
   rbs_crc16 u_crc (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .clear_i (readback_trigger_rise && state_r == rbs_pkg::ST_IDLE),
      .step_i  (crc_step),
      .bit_i   (frame_bit),
      .crc_o   (crc)
   );

   // -------------------------------------------------------------
   // sequencer: counters lead the output by one bit
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r                    <= rbs_pkg::ST_IDLE;
         cnt_r                      <= 5'h00;
         frame_r                    <= 2'h0;
         readback_data_pin_o        <= 1'b1;
         readback_in_progress_pin_o <= 1'b0;
      end else if (rb_edge) begin
         if (abort_req) begin
            state_r                    <= rbs_pkg::ST_TERM;
            cnt_r                      <= 5'h00;
            readback_data_pin_o        <= 1'b1;
            // an abort on the first edge still owes the flag its rise
            readback_in_progress_pin_o <= 1'b1;
         end else begin
            case (state_r)
               rbs_pkg::ST_IDLE: begin
                  readback_data_pin_o        <= 1'b1;
                  readback_in_progress_pin_o <= 1'b0;
                  if (readback_trigger_rise) begin
                     state_r <= rbs_pkg::ST_DUMMY;
                     cnt_r   <= 5'h00;
                  end
               end
               rbs_pkg::ST_DUMMY: begin
                  readback_in_progress_pin_o <= 1'b1;
                  readback_data_pin_o        <= 1'b1;
                  if (cnt_r == 5'(rbs_pkg::DUMMY_BITS - 1)) begin
                     state_r <= rbs_pkg::ST_FRAME;
                     cnt_r   <= 5'h00;
                     frame_r <= 2'h0;
                  end else begin
                     cnt_r <= cnt_r + 5'h01;
                  end
               end
               rbs_pkg::ST_FRAME: begin
                  readback_data_pin_o <= frame_bit;
                  if (cnt_r == 5'(rbs_pkg::FRAME_LAST_OFF)) begin
                     cnt_r <= 5'h00;
                     if (frame_r == 2'(rbs_pkg::NUM_FRAMES - 1)) begin
                        state_r <= rbs_pkg::ST_CRC;
                     end else begin
                        frame_r <= frame_r + 2'h1;
                     end
                  end else begin
                     cnt_r <= cnt_r + 5'h01;
                  end
               end
               rbs_pkg::ST_CRC: begin
                  readback_data_pin_o <= crc[4'(rbs_pkg::CRC_WIDTH - 1) - 4'(cnt_r)];
                  if (cnt_r == 5'(rbs_pkg::CRC_OUT_BITS - 1)) begin
                     state_r <= rbs_pkg::ST_DONE;
                  end else begin
                     cnt_r <= cnt_r + 5'h01;
                  end
               end
               rbs_pkg::ST_DONE: begin
                  // the edge that shifts the last bit out ends the readback
                  readback_in_progress_pin_o <= 1'b0;
                  readback_data_pin_o        <= 1'b1;
                  state_r                    <= rbs_pkg::ST_IDLE;
               end
               rbs_pkg::ST_TERM: begin
                  readback_data_pin_o <= 1'b1;
                  if (cnt_r == 5'(rbs_pkg::TERM_CLKS - 1)) begin
                     readback_in_progress_pin_o <= 1'b0;
                     state_r                    <= rbs_pkg::ST_IDLE;
                     cnt_r                      <= 5'h00;
                  end else begin
                     cnt_r <= cnt_r + 5'h01;
                  end
               end
               default: begin
                  state_r <= rbs_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_rip_rise_after: assert property (@(posedge clk_i) disable iff (reset_i)
      (rb_edge && state_r == rbs_pkg::ST_DUMMY && cnt_r == 5'h00) |=> $rose(readback_in_progress_pin_o))
      else $error("in-progress did not rise one readback clock after trigger");

   a_trigger_starts: assert property (@(posedge clk_i) disable iff (reset_i)
      (readback_trigger_rise && state_r == rbs_pkg::ST_IDLE) |=> state_r == rbs_pkg::ST_DUMMY && !readback_in_progress_pin_o)
      else $error("rising trigger did not start readback");

   a_dummy_ones: assert property (@(posedge clk_i) disable iff (reset_i)
      (rb_edge && state_r == rbs_pkg::ST_DUMMY && !abort_req) |=> readback_data_pin_o)
      else $error("dummy bit not one");

   a_start_bit_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      (rb_edge && state_r == rbs_pkg::ST_FRAME && cnt_r == 5'h00 && !abort_req) |=> !readback_data_pin_o)
      else $error("frame start bit not zero");

   a_stop_bits_ones: assert property (@(posedge clk_i) disable iff (reset_i)
      (rb_edge && state_r == rbs_pkg::ST_FRAME && cnt_r > 5'h10 && !abort_req) |=> readback_data_pin_o)
      else $error("frame stop bit not one");

   a_crc_msb_out: assert property (@(posedge clk_i) disable iff (reset_i)
      (rb_edge && state_r == rbs_pkg::ST_CRC && cnt_r == 5'h00 && !abort_req) |=> readback_data_pin_o == $past(crc[15]))
      else $error("signature does not open with CRC msb");

   a_abort_term: assert property (@(posedge clk_i) disable iff (reset_i)
      abort_req |=> state_r == rbs_pkg::ST_TERM && readback_in_progress_pin_o && readback_data_pin_o)
      else $error("abort not taken");

   a_term_data_high: assert property (@(posedge clk_i) disable iff (reset_i)
      state_r == rbs_pkg::ST_TERM |-> readback_data_pin_o && readback_in_progress_pin_o)
      else $error("termination data or in-progress dropped early");

   a_rip_fall_done: assert property (@(posedge clk_i) disable iff (reset_i)
      (rb_edge && state_r == rbs_pkg::ST_DONE) |=> !readback_in_progress_pin_o && state_r == rbs_pkg::ST_IDLE)
      else $error("in-progress not low after last bit");

   a_rip_idle_low: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_r == rbs_pkg::ST_IDLE) |-> !readback_in_progress_pin_o)
      else $error("in-progress high while idle");

   a_nocap_user_ones: assert property (@(posedge clk_i) disable iff (reset_i)
      (readback_trigger_rise && state_r == rbs_pkg::ST_IDLE && !user_state_capture_option_i) |=> hold_r[3] && hold_r[7])
      else $error("user bits not ones with capture disabled");

   a_last_seven_ones: assert property (@(posedge clk_i) disable iff (reset_i)
      state_r != rbs_pkg::ST_IDLE |-> &hold_r[63:57])
      else $error("last seven bits of last frame not ones");
endmodule // rbs_readback_shifter

// [design/rbs_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rbs_sync #(
   parameter int WIDTH = 1
) (
   // clock and control
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             ce_i,
   // async in, synced out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else if (ce_i) begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule // rbs_sync

// [test/config_state_readback_shifter_bench.sv]
// self-checking bench for the configuration readback shifter
`timescale 1ns/1ps
module config_state_readback_shifter_bench;
   logic        clk_i       = 1'b0;
   logic        reset_i     = 1'b1;
   logic        ce          = 1'b1;
   logic        junk_clk    = 1'b0;
   logic        user_sel    = 1'b1;
   logic        abort_opt   = 1'b0;
   logic        capture_opt = 1'b0;
   logic        spd         = 1'b0;
   logic        chk         = 1'b0;
   logic        cfg_wr      = 1'b0;
   logic [1:0]  cfg_addr    = 2'h0;
   logic [15:0] cfg_data    = 16'h0000;
   logic [63:0] nodes       = 64'h0000000000000000;
   logic [15:0] mem [4];
   wire         rb_clk;
   wire         readback_trigger;
   wire         data_o;
   wire         rip_o;
   integer      num_errors  = 0;
   integer      tests_run   = 0;
   integer      seed        = 21407;

   always #5 clk_i = ~clk_i;
   // the unselected clock pin toggles so a wrong select shows up
   always #41 junk_clk = ~junk_clk;

   rbs_readback_shifter dut_u (
      .clk_i                          (clk_i),
      .reset_i                        (reset_i),
      .ce_i                           (ce),
      .readback_clk_pin_i             (user_sel ? rb_clk : junk_clk),
      .config_clk_pin_i               (user_sel ? junk_clk : rb_clk),
      .readback_trigger_pin_i         (readback_trigger),
      .readback_data_pin_o            (data_o),
      .readback_in_progress_pin_o     (rip_o),
      .user_clk_connected_i           (user_sel),
      .abort_on_trigger_fall_option_i (abort_opt),
      .user_state_capture_option_i    (capture_opt),
      .cfg_speed_i                    (spd),
      .cfg_check_mode_i               (chk),
      .cfg_wr_i                       (cfg_wr),
      .cfg_addr_i                     (cfg_addr),
      .cfg_data_i                     (cfg_data),
      .user_nodes_i                   (nodes)
   );

   rbs_tester_model partner_u (
      .rb_clk_o (rb_clk),
      .readback_trigger_o   (readback_trigger),
      .data_i   (data_o),
      .rip_i    (rip_o)
   );

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task check(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task load_cfg;
      for (int a = 0; a < 4; a++) begin
         @(negedge clk_i);
         mem[a]   = 16'($random(seed));
         cfg_wr   = 1'b1;
         cfg_addr = 2'(a);
         cfg_data = mem[a];
      end
      @(negedge clk_i);
      cfg_wr = 1'b0;
      spd    = 1'($random(seed));
      chk    = 1'($random(seed));
   endtask

   function automatic logic hold_bit(int i);
      if (i >= 57) return 1'b1;
      if (i == 0) return spd;
      if (i == 1) return chk;
      if (i % 4 == 3) return capture_opt ? ~nodes[i] : 1'b1;
      return mem[i / 16][i % 16];
   endfunction

   // reference stream: dummies, framed data, top crc bits
   task automatic run_rb(input int abort_at, input string name);
      logic s[$];
      logic [15:0] crc;
      logic b, d, r, t;
      int n;
      crc = 16'h0000;
      for (int i = 0; i < rbs_pkg::DUMMY_BITS; i++) s.push_back(1'b1);
      for (int f = 0; f < rbs_pkg::NUM_FRAMES; f++) begin
         for (int j = 0; j < 21; j++) begin
            b = (j == 0) ? 1'b0 : (j > 16) ? 1'b1 : hold_bit(f * 16 + j - 1);
            s.push_back(b);
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? rbs_pkg::CRC_POLY : 16'h0000);
         end
      end
      for (int j = 15; j >= 5; j--) s.push_back(crc[j]);
      for (int k = 0; k < 3; k++) begin
         partner_u.rb_edge(1'b0, d, r);
         check(r, 1'b0, "idle rip");
         check(d, 1'b1, "idle data");
      end
      n = s.size() + 1;
      for (int k = 0; k <= n; k++) begin
         // without abort the trigger drops and comes back mid run
         t = (abort_at > 0) ? (k < abort_at) : (k < 3 || (k >= 40 && k < 45));
         partner_u.rb_edge(t, d, r);
         if (k == 1) begin
            @(negedge clk_i);
            nodes = {$random(seed), $random(seed)};
         end
         if (abort_at > 0 && k >= abort_at) begin
            check(d, 1'b1, "term data");
            check(r, k < abort_at + rbs_pkg::TERM_CLKS, "term rip");
            if (k == abort_at + rbs_pkg::TERM_CLKS) break;
         end else begin
            check(d, (k >= 1 && k < n) ? s[k - 1] : 1'b1, "data");
            check(r, k >= 1 && k < n, "rip");
         end
         // a low enable swallows a whole readback period, stream must not move
         if (k == 1 && abort_at == 0) begin
            ce = 1'b0;
            partner_u.rb_edge(t, d, r);
            check(d, s[0], "frozen data");
            check(r, 1'b1, "frozen rip");
            @(negedge clk_i);
            ce = 1'b1;
         end
      end
      $display("test %s done", name);
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      load_cfg();
      run_rb(0, "capture off");
      run_rb(0, "repeat signature");
      @(negedge clk_i);
      capture_opt = 1'b1;
      nodes       = {$random(seed), $random(seed)};
      run_rb(0, "capture on");
      @(negedge clk_i);
      abort_opt = 1'b1;
      run_rb(30, "abort");
      run_rb(1, "early abort");
      @(negedge clk_i);
      abort_opt = 1'b0;
      user_sel  = 1'b0;
      load_cfg();
      run_rb(0, "config clock");
      end_of_test();
   end

   // six runs, four of about 106 readback periods each and two cut short by an abort
   initial begin
      #200000;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // config_state_readback_shifter_bench

// [test/rbs_tester_model.sv]
// tester model that clocks readback and drives the trigger
`timescale 1ns/1ps
module rbs_tester_model (
   // readback link out
   output logic      rb_clk_o,
   output logic      readback_trigger_o,
   // readback link in
   input  wire logic data_i,
   input  wire logic rip_i
);
   // clock stands still low between calls, as a tester would leave it
   initial begin
      rb_clk_o = 1'b0;
      readback_trigger_o   = 1'b0;
   end
   // -------------------------------------------------------------
   // one readback clock period
   // -------------------------------------------------------------
   // trigger moves only mid low phase, so it stays put a full period
   task rb_edge(input logic readback_trigger, output logic data, output logic readback_in_progress);
      #31.25 readback_trigger_o = readback_trigger;
      #31.25 rb_clk_o = 1'b1;
      #62.5 rb_clk_o = 1'b0;
      // outputs settle well inside the high phase
      data = data_i;
      readback_in_progress  = rip_i;
   endtask
endmodule // rbs_tester_model
